// *** src/msc_pkg.sv ***
package msc_pkg;

  // ***************************************************************
  // Bus and register map
  // ***************************************************************
  localparam int unsigned AXI_AW   = 8;
  localparam int unsigned AXI_DW   = 32;
  localparam int unsigned HOST_AW  = 24;

  localparam logic [7:0]  OFS_CFG  = 8'h00;
  localparam logic [7:0]  OFS_ID0  = 8'h04;
  localparam logic [7:0]  OFS_ID1  = 8'h08;
  localparam logic [7:0]  OFS_CTRL = 8'h0C;
  localparam logic [7:0]  OFS_MAP  = 8'h10;
  localparam logic [7:0]  OFS_STAT = 8'h14;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ***************************************************************
  // Memory-space configuration fields
  // ***************************************************************
  localparam int unsigned CFG_SRAM_FETCH = 0;
  localparam int unsigned CFG_SEC_FETCH  = 1;
  localparam int unsigned CFG_PRI_FETCH  = 2;
  localparam int unsigned CFG_SEC_READ   = 3;
  localparam int unsigned CFG_PRI_READ   = 4;
  localparam int unsigned CFG_PERIPH     = 7;
  localparam int unsigned CFG_IMG_LSB    = 1;
  localparam int unsigned CFG_IMG_MSB    = 4;
  localparam logic [7:0]  CFG_USED_MASK  = 8'h9F;
  localparam logic [7:0]  CFG_RST        = 8'h00;

  // ***************************************************************
  // Identification fields
  // ***************************************************************
  localparam int unsigned ID_LO_LSB       = 0;
  localparam int unsigned ID_HI_LSB       = 4;
  localparam logic [3:0]  PRI_SIZE_CODE   = 4'h6;
  localparam logic [3:0]  SRAM_SIZE_CODE  = 4'h5;
  localparam logic [3:0]  SEC_SIZE_CODE   = 4'h3;
  localparam logic [1:0]  SEC_TYPE_FLASH  = 2'h0;
  localparam logic [1:0]  SEC_TYPE_EEPROM = 2'h1;

  // ***************************************************************
  // Control, map and status fields
  // ***************************************************************
  localparam int unsigned CTRL_SPLIT   = 0;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam int unsigned MAP_PRI_LSB  = 0;
  localparam int unsigned MAP_SEC_LSB  = 8;
  localparam int unsigned MAP_SRAM_LSB = 16;
  localparam logic [31:0] MAP_RST      = 32'h0022_1000;
  localparam int unsigned STAT_DENY    = 31;

  // ***************************************************************
  // Memory organisation
  // ***************************************************************
  localparam int unsigned PRI_SECTORS  = 16;
  localparam int unsigned SEC_SECTORS  = 4;
  localparam int unsigned PRI_BASE_LSB = 20;
  localparam int unsigned PRI_SECT_LSB = 16;
  localparam int unsigned SEC_BASE_LSB = 16;
  localparam int unsigned SRAM_BASE_LSB = 15;
  localparam logic [15:0] SEC_S1_OFS   = 16'h4000;
  localparam logic [15:0] SEC_S2_OFS   = 16'h6000;
  localparam logic [15:0] SEC_S3_OFS   = 16'h8000;

  typedef struct packed {
    logic [HOST_AW-1:0] addr;
    logic               fetch;
    logic               read;
    logic               write;
  } msc_host_t;

  typedef struct packed {
    logic pri_fetch;
    logic sec_fetch;
    logic sram_fetch;
    logic pri_read;
    logic sec_read;
  } msc_gate_t;

  typedef struct packed {
    logic [8:0] sram;
    logic [7:0] sec;
    logic [3:0] pri;
  } msc_map_t;

  typedef struct packed {
    logic [PRI_SECTORS-1:0] pri;
    logic [SEC_SECTORS-1:0] sec;
    logic                   sram;
  } msc_sel_t;

endpackage : msc_pkg

// *** src/msc_axil_slave.sv ***
`timescale 1ns/100ps
module msc_axil_slave
  import msc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic [AXI_AW-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [AXI_DW-1:0] i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [AXI_AW-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [AXI_DW-1:0]      o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_wr_fire,
  output logic [AXI_AW-1:0]      o_wr_addr,
  output logic [AXI_DW-1:0]      o_wr_data,
  output logic [3:0]             o_wr_strb,
  input  wire logic              i_wr_err,
  output logic                   o_rd_fire,
  output logic [AXI_AW-1:0]      o_rd_addr,
  input  wire logic [AXI_DW-1:0] i_rd_data,
  input  wire logic              i_rd_err
);

  logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [AXI_DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;

  assign o_awready = !aw_hold_q && !bvalid_q;
  assign o_wready  = !w_hold_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_wr_fire = aw_hold_q && w_hold_q;
  assign o_wr_addr = awaddr_q;
  assign o_wr_data = wdata_q;
  assign o_wr_strb = wstrb_q;
  assign o_rd_fire = i_arvalid && !rvalid_q;
  assign o_rd_addr = i_araddr;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_rvalid  = rvalid_q;
  assign o_rresp   = rresp_q;
  assign o_rdata   = rdata_q;

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (i_awvalid && o_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d  = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_hold_d = 1'b1;
      wdata_d  = i_wdata;
      wstrb_d  = i_wstrb;
    end
    if (o_wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = i_wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (o_rd_fire) begin
      rvalid_d = 1'b1;
      rdata_d  = i_rd_data;
      rresp_d  = i_rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

endmodule : msc_axil_slave

// *** src/msc_sector_decode.sv ***
`timescale 1ns/100ps
module msc_sector_decode
  import msc_pkg::*;
(
  input  wire msc_host_t i_host,
  input  wire msc_gate_t i_gate,
  input  wire msc_map_t  i_map,
  output msc_sel_t       o_sel,
  output logic           o_deny
);

  // Three product terms: gated fetch, gated read, write
  function automatic logic sel_terms(input logic hit, input logic fetch_ok,
                                     input logic read_ok, input msc_host_t h);
    sel_terms = hit && ((h.fetch && fetch_ok) || (h.read && read_ok) || h.write);
  endfunction : sel_terms

  function automatic logic [1:0] sec_index(input logic [15:0] ofs);
    if (ofs < SEC_S1_OFS) begin
      sec_index = 2'h0;
    end else if (ofs < SEC_S2_OFS) begin
      sec_index = 2'h1;
    end else if (ofs < SEC_S3_OFS) begin
      sec_index = 2'h2;
    end else begin
      sec_index = 2'h3;
    end
  endfunction : sec_index

  logic       pri_hit, sec_hit, sram_hit;
  logic [1:0] sec_idx;

  assign pri_hit  = i_host.addr[HOST_AW-1:PRI_BASE_LSB] == i_map.pri;
  assign sec_hit  = i_host.addr[HOST_AW-1:SEC_BASE_LSB] == i_map.sec;
  assign sram_hit = i_host.addr[HOST_AW-1:SRAM_BASE_LSB] == i_map.sram;
  assign sec_idx  = sec_index(i_host.addr[15:0]);

  // ***************************************************************
  // Select equations
  // ***************************************************************
  for (genvar s = 0; s < PRI_SECTORS; s++) begin : g_pri
    assign o_sel.pri[s] = sel_terms(pri_hit && (i_host.addr[PRI_BASE_LSB-1:PRI_SECT_LSB]
                          == 4'(s)), i_gate.pri_fetch, i_gate.pri_read, i_host); // [RQ15] [RQ6] [RQ8]
  end
  for (genvar s = 0; s < SEC_SECTORS; s++) begin : g_sec
    assign o_sel.sec[s] = sel_terms(sec_hit && (sec_idx == 2'(s)),
                          i_gate.sec_fetch, i_gate.sec_read, i_host); // [RQ15] [RQ5] [RQ7]
  end
  assign o_sel.sram = sel_terms(sram_hit, i_gate.sram_fetch, 1'b1, i_host); // [RQ17] [RQ4]

  assign o_deny = (i_host.fetch && ((pri_hit && !i_gate.pri_fetch)
                  || (sec_hit && !i_gate.sec_fetch) || (sram_hit && !i_gate.sram_fetch)))
               || (i_host.read && ((pri_hit && !i_gate.pri_read)
                  || (sec_hit && !i_gate.sec_read)));

endmodule : msc_sector_decode

// *** src/msc_memory_space.sv ***
// How it works
// [RQ1] Reset clears the SRAM fetch bit and the port peripheral mode bit.
// [RQ2] Bits one to four load from the user configuration image after reset.
// [RQ3] Gating bits act only in split code/data mode, otherwise ignored.
// [RQ4] SRAM fetch bit lets program fetches reach SRAM.
// [RQ5] Secondary fetch bit lets program fetches reach secondary memory.
// [RQ6] Primary fetch bit lets program fetches reach primary flash.
// [RQ7] Secondary read bit lets data reads reach secondary memory.
// [RQ8] Primary read bit lets data reads reach primary flash.
// [RQ9] Top configuration bit enables the port peripheral mode.
// [RQ10] First ID low nibble gives primary flash size code.
// [RQ11] First ID high nibble gives SRAM size code.
// [RQ12] Second ID low nibble gives secondary memory size code.
// [RQ13] Two-bit type above it: flash reads 0, EEPROM reads 1.
// [RQ14] Sector and block selects come from user-defined decode equations.
// [RQ15] Sixteen primary and four secondary selects, three product terms each.
// [RQ16] All primary and secondary sector selects are active high.
// [RQ17] SRAM has one single block select, no sectors.
// [RQ18] Map: 16x64K primary, 16K/8K/8K/32K secondary, 32K SRAM.
// [RQ19] Unused register bits read zero; writes to them are dropped.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module msc_memory_space
  import msc_pkg::*;
#(
  parameter logic [1:0] SEC_TYPE = SEC_TYPE_FLASH
)
(
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_ARST_N,
  input  wire logic [AXI_AW-1:0]      I_AWADDR,
  input  wire logic                   I_AWVALID,
  output logic                        O_AWREADY,
  input  wire logic [AXI_DW-1:0]      I_WDATA,
  input  wire logic [3:0]             I_WSTRB,
  input  wire logic                   I_WVALID,
  output logic                        O_WREADY,
  output logic [1:0]                  O_BRESP,
  output logic                        O_BVALID,
  input  wire logic                   I_BREADY,
  input  wire logic [AXI_AW-1:0]      I_ARADDR,
  input  wire logic                   I_ARVALID,
  output logic                        O_ARREADY,
  output logic [AXI_DW-1:0]           O_RDATA,
  output logic [1:0]                  O_RRESP,
  output logic                        O_RVALID,
  input  wire logic                   I_RREADY,
  input  wire logic [CFG_IMG_MSB:CFG_IMG_LSB] I_CFG_IMAGE,
  input  wire logic [HOST_AW-1:0]     I_HOST_ADDR,
  input  wire logic                   I_PROGRAM_FETCH_STROBE_N,
  input  wire logic                   I_READ_STROBE_N,
  input  wire logic                   I_WRITE_STROBE_N,
  output logic [PRI_SECTORS-1:0]      O_PRIMARY_SECTOR_SELECTS,
  output logic [SEC_SECTORS-1:0]      O_SECONDARY_SECTOR_SELECTS,
  output logic                        O_SRAM_BLOCK_SELECT,
  output logic                        O_PORT_PERIPH_MODE
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    merge_bytes = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge_bytes[8*b +: 8] = new_v[8*b +: 8];
      end
    end
  endfunction : merge_bytes

  function automatic logic is_reg(input logic [AXI_AW-1:0] a, input logic [7:0] ofs);
    is_reg = {a[AXI_AW-1:2], 2'h0} == ofs;
  endfunction : is_reg

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    is_mapped = is_reg(a, OFS_CFG) || is_reg(a, OFS_ID0) || is_reg(a, OFS_ID1)
             || is_reg(a, OFS_CTRL) || is_reg(a, OFS_MAP) || is_reg(a, OFS_STAT);
  endfunction : is_mapped

  // ***************************************************************
  // Bus slave
  // ***************************************************************
  logic              wr_fire, rd_fire, wr_err, rd_err;
  logic [AXI_AW-1:0] wr_addr, rd_addr;
  logic [AXI_DW-1:0] wr_data, rd_data;
  logic [3:0]        wr_strb;

  msc_axil_slave u_slave (
    .i_clk     (I_CORE_CLK),
    .i_arst_n  (I_ARST_N),
    .i_awaddr  (I_AWADDR),
    .i_awvalid (I_AWVALID),
    .o_awready (O_AWREADY),
    .i_wdata   (I_WDATA),
    .i_wstrb   (I_WSTRB),
    .i_wvalid  (I_WVALID),
    .o_wready  (O_WREADY),
    .o_bresp   (O_BRESP),
    .o_bvalid  (O_BVALID),
    .i_bready  (I_BREADY),
    .i_araddr  (I_ARADDR),
    .i_arvalid (I_ARVALID),
    .o_arready (O_ARREADY),
    .o_rdata   (O_RDATA),
    .o_rresp   (O_RRESP),
    .o_rvalid  (O_RVALID),
    .i_rready  (I_RREADY),
    .o_wr_fire (wr_fire),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_fire (rd_fire),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  assign wr_err = !is_mapped(wr_addr);
  assign rd_err = !is_mapped(rd_addr);

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [7:0]  cfg_q, cfg_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [31:0] map_q, map_d;
  logic        load_pend_q, load_pend_d;
  logic        deny_q, deny_d;
  logic        deny;
  msc_sel_t    sel_q, sel_d;
  logic [31:0] wr_word;

  localparam logic [31:0] MAP_RST_MASK = 32'h01FF_FF0F;

  always_comb begin
    cfg_d       = cfg_q;
    ctrl_d      = ctrl_q;
    map_d       = map_q;
    load_pend_d = 1'b0;
    deny_d      = deny_q;
    wr_word     = '0;
    if (load_pend_q) begin
      cfg_d[CFG_IMG_MSB:CFG_IMG_LSB] = I_CFG_IMAGE; // [RQ2]
    end
    if (wr_fire) begin
      if (is_reg(wr_addr, OFS_CFG)) begin
        wr_word = merge_bytes({24'h0, cfg_q}, wr_data, wr_strb);
        cfg_d   = wr_word[7:0] & CFG_USED_MASK; // [RQ19]
      end
      if (is_reg(wr_addr, OFS_CTRL)) begin
        wr_word = merge_bytes({24'h0, ctrl_q}, wr_data, wr_strb);
        ctrl_d  = wr_word[7:0] & (8'h01 << CTRL_SPLIT); // [RQ19]
      end
      if (is_reg(wr_addr, OFS_MAP)) begin
        map_d = merge_bytes(map_q, wr_data, wr_strb) & MAP_RST_MASK; // [RQ14] [RQ19]
      end
      if (is_reg(wr_addr, OFS_STAT) && wr_strb[3] && wr_data[STAT_DENY]) begin
        deny_d = 1'b0;
      end
    end
    if (deny) begin
      deny_d = 1'b1;
    end
  end


  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_q       <= CFG_RST; // [RQ1]
      ctrl_q      <= CTRL_RST;
      map_q       <= MAP_RST;
      load_pend_q <= 1'b1;
      deny_q      <= 1'b0;
    end else begin
      cfg_q       <= cfg_d;
      ctrl_q      <= ctrl_d;
      map_q       <= map_d;
      load_pend_q <= load_pend_d;
      deny_q      <= deny_d;
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  logic [7:0] id0, id1;

  assign id0 = {SRAM_SIZE_CODE, PRI_SIZE_CODE}; // [RQ10] [RQ11]
  assign id1 = {2'h0, SEC_TYPE, SEC_SIZE_CODE}; // [RQ12] [RQ13] [RQ19]

  always_comb begin
    rd_data = '0;
    if (is_reg(rd_addr, OFS_CFG)) begin
      rd_data[7:0] = cfg_q;
    end
    if (is_reg(rd_addr, OFS_ID0)) begin
      rd_data[7:0] = id0;
    end
    if (is_reg(rd_addr, OFS_ID1)) begin
      rd_data[7:0] = id1;
    end
    if (is_reg(rd_addr, OFS_CTRL)) begin
      rd_data[7:0] = ctrl_q;
    end
    if (is_reg(rd_addr, OFS_MAP)) begin
      rd_data = map_q;
    end
    if (is_reg(rd_addr, OFS_STAT)) begin
      rd_data = {deny_q, 10'h0, sel_q};
    end
  end

  // ***************************************************************
  // Access gating and select decode
  // ***************************************************************
  msc_host_t host;
  msc_gate_t gate;
  msc_map_t  map_f;
  msc_sel_t  sel_c;
  logic      split;

  assign host.addr  = I_HOST_ADDR;
  assign host.fetch = !I_PROGRAM_FETCH_STROBE_N;
  assign host.read  = !I_READ_STROBE_N;
  assign host.write = !I_WRITE_STROBE_N;

  assign split = ctrl_q[CTRL_SPLIT];

  // Outside split mode every fetch and read is allowed
  assign gate.sram_fetch = !split || cfg_q[CFG_SRAM_FETCH]; // [RQ3] [RQ4]
  assign gate.sec_fetch  = !split || cfg_q[CFG_SEC_FETCH];  // [RQ3] [RQ5]
  assign gate.pri_fetch  = !split || cfg_q[CFG_PRI_FETCH];  // [RQ3] [RQ6]
  assign gate.sec_read   = !split || cfg_q[CFG_SEC_READ];   // [RQ3] [RQ7]
  assign gate.pri_read   = !split || cfg_q[CFG_PRI_READ];   // [RQ3] [RQ8]

  assign map_f.pri  = map_q[MAP_PRI_LSB +: 4];
  assign map_f.sec  = map_q[MAP_SEC_LSB +: 8];
  assign map_f.sram = map_q[MAP_SRAM_LSB +: 9];

  msc_sector_decode u_decode (
    .i_host (host),
    .i_gate (gate),
    .i_map  (map_f),
    .o_sel  (sel_c),
    .o_deny (deny)
  ); // [RQ14] [RQ18]

  assign sel_d = sel_c;

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign O_PRIMARY_SECTOR_SELECTS   = sel_q.pri;  // [RQ16]
  assign O_SECONDARY_SECTOR_SELECTS = sel_q.sec;  // [RQ16]
  assign O_SRAM_BLOCK_SELECT        = sel_q.sram; // [RQ17]
  assign O_PORT_PERIPH_MODE         = cfg_q[CFG_PERIPH]; // [RQ9]

endmodule : msc_memory_space

// *** test/msc_chk.sv ***
`timescale 1ns/100ps
module msc_chk
  import msc_pkg::*;
#(
  parameter logic [1:0] SEC_TYPE = SEC_TYPE_FLASH
)
(
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_ARST_N,
  input  wire logic [AXI_AW-1:0]      I_ARADDR,
  input  wire logic                   I_ARVALID,
  input  wire logic                   O_ARREADY,
  input  wire logic [AXI_DW-1:0]      O_RDATA,
  input  wire logic                   O_RVALID,
  input  wire logic [HOST_AW-1:0]     I_HOST_ADDR,
  input  wire logic                   I_PROGRAM_FETCH_STROBE_N,
  input  wire logic                   I_READ_STROBE_N,
  input  wire logic                   I_WRITE_STROBE_N,
  input  wire logic [PRI_SECTORS-1:0] O_PRIMARY_SECTOR_SELECTS,
  input  wire logic [SEC_SECTORS-1:0] O_SECONDARY_SECTOR_SELECTS,
  input  wire logic                   O_SRAM_BLOCK_SELECT,
  input  wire logic                   O_PORT_PERIPH_MODE
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  wire wr = !I_WRITE_STROBE_N;
  property p_rst_periph;
    $past(!I_ARST_N) |-> !O_PORT_PERIPH_MODE;
  endproperty
  a_rst_periph: assert property (p_rst_periph) else $error("periph mode after reset");
  property p_idle;
    I_PROGRAM_FETCH_STROBE_N && I_READ_STROBE_N && !wr
      |=> {O_PRIMARY_SECTOR_SELECTS, O_SECONDARY_SECTOR_SELECTS, O_SRAM_BLOCK_SELECT} == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("select without strobe");
  property p_pri;
    wr && I_HOST_ADDR[23:20] == 4'h0
      |=> O_PRIMARY_SECTOR_SELECTS == (16'h1 << $past(I_HOST_ADDR[19:16]));
  endproperty
  a_pri: assert property (p_pri) else $error("primary sector decode");
  property p_onehot;
    $onehot0(O_PRIMARY_SECTOR_SELECTS);
  endproperty
  a_onehot: assert property (p_onehot) else $error("several primary selects");
  property p_sec;
    wr && I_HOST_ADDR[23:16] == 8'h10 |=> O_SECONDARY_SECTOR_SELECTS ==
      ($past(I_HOST_ADDR[15]) ? 4'h8 : $past(I_HOST_ADDR[14]) ?
       ($past(I_HOST_ADDR[13]) ? 4'h4 : 4'h2) : 4'h1);
  endproperty
  a_sec: assert property (p_sec) else $error("secondary sector decode");
  property p_sram;
    wr |=> O_SRAM_BLOCK_SELECT == ($past(I_HOST_ADDR[23:15]) == 9'h022);
  endproperty
  a_sram: assert property (p_sram) else $error("sram select decode");
  property p_id0;
    I_ARVALID && O_ARREADY && I_ARADDR == OFS_ID0 |=> O_RVALID && O_RDATA == 32'h56;
  endproperty
  a_id0: assert property (p_id0) else $error("first id value");
  property p_id1;
    I_ARVALID && O_ARREADY && I_ARADDR == OFS_ID1
      |=> O_RVALID && O_RDATA == {26'h0, SEC_TYPE, SEC_SIZE_CODE};
  endproperty
  a_id1: assert property (p_id1) else $error("second id value");
endmodule : msc_chk

bind msc_memory_space msc_chk #(.SEC_TYPE(SEC_TYPE)) u_msc_chk (
  .I_CORE_CLK, .I_ARST_N, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RVALID,
  .I_HOST_ADDR, .I_PROGRAM_FETCH_STROBE_N, .I_READ_STROBE_N, .I_WRITE_STROBE_N,
  .O_PRIMARY_SECTOR_SELECTS, .O_SECONDARY_SECTOR_SELECTS, .O_SRAM_BLOCK_SELECT,
  .O_PORT_PERIPH_MODE
);

// *** test/msc_host_model.sv ***
`timescale 1ns/100ps
module msc_host_model
  import msc_pkg::*;
(
  input  wire logic          i_clk,
  output logic [HOST_AW-1:0] o_addr,
  output logic               o_fetch_n,
  output logic               o_read_n,
  output logic               o_write_n
);
  initial begin
    o_addr = '0;
    o_fetch_n = 1'b1;
    o_read_n = 1'b1;
    o_write_n = 1'b1;
  end
  // One host cycle: kind 0 fetch, 1 read, 2 write; address scrambled when released
  task automatic access(input logic [HOST_AW-1:0] a, input logic [1:0] k);
    @(posedge i_clk);
    o_addr <= a;
    o_fetch_n <= (k != 2'h0);
    o_read_n <= (k != 2'h1);
    o_write_n <= (k != 2'h2);
    @(posedge i_clk);
    o_addr <= ~a;
    o_fetch_n <= 1'b1;
    o_read_n <= 1'b1;
    o_write_n <= 1'b1;
  endtask : access
endmodule : msc_host_model

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench
  import msc_pkg::*;
;
  logic               clk = 1'b0, rst_n = 1'b0;
  logic [AXI_AW-1:0]  awaddr = '0, araddr = '0;
  logic [AXI_DW-1:0]  wdata = '0, rdata;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic               sram_sel, periph, fetch_n, read_n, write_n;
  logic [1:0]         bresp, rresp;
  logic [HOST_AW-1:0] haddr;
  logic [15:0]        pri_sel;
  logic [3:0]         sec_sel, img = 4'hA;
  int                 failures = 0, checks_done = 0, cycles = 0;
  always #4 clk = ~clk;
  msc_memory_space u_msc_memory_space (
    .I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_CFG_IMAGE(img),
    .I_HOST_ADDR(haddr), .I_PROGRAM_FETCH_STROBE_N(fetch_n), .I_READ_STROBE_N(read_n),
    .I_WRITE_STROBE_N(write_n), .O_PRIMARY_SECTOR_SELECTS(pri_sel),
    .O_SECONDARY_SECTOR_SELECTS(sec_sel), .O_SRAM_BLOCK_SELECT(sram_sel),
    .O_PORT_PERIPH_MODE(periph));
  msc_host_model u_msc_host_model (
    .i_clk(clk), .o_addr(haddr), .o_fetch_n(fetch_n), .o_read_n(read_n),
    .o_write_n(write_n));
  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      #1 ta = awready;
      tw = wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!((ta || !awvalid) && (tw || !wvalid)));
    do begin
      #1 tb = bvalid;
      r = bresp;
      @(posedge clk);
    end while (tb !== 1'b1);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1 t = arready;
      @(posedge clk);
    end while (t !== 1'b1);
    arvalid <= 1'b0;
    do begin
      #1 t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (t !== 1'b1);
    rready <= 1'b0;
  endtask : axr
  task automatic hchk(input logic [23:0] a, input logic [1:0] k, input logic [20:0] e);
    u_msc_host_model.access(a, k);
    #1 chk({11'h0, pri_sel, sec_sel, sram_sel}, {11'h0, e});
  endtask : hchk
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    axr(OFS_CFG, d, r);
    chk(d, 32'h14);
    axw(OFS_CFG, 32'hFF, r);
    axr(OFS_CFG, d, r);
    chk(d, 32'h9F);
    #1 chk({31'h0, periph}, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    img <= 4'h5;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    axr(OFS_CFG, d, r);
    chk(d, 32'h0A);
    #1 chk({31'h0, periph}, 32'h0);
  endtask : t_reset
  task automatic t_ids;
    logic [31:0] d;
    logic [1:0]  r;
    axw(OFS_ID0, 32'h0, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    axr(OFS_ID0, d, r);
    chk(d, 32'h56);
    axr(OFS_ID1, d, r);
    chk(d, 32'h03);
    axr(8'h3C, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
  endtask : t_ids
  task automatic t_gate;
    logic [23:0] a;
    logic [1:0]  k, r;
    logic [20:0] e;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: begin a = 24'h110000; k = 2'h0; e = 21'h1; end
        1: begin a = 24'h100000; k = 2'h0; e = 21'h2; end
        2: begin a = 24'h030000; k = 2'h0; e = 21'h100; end
        3: begin a = 24'h108000; k = 2'h1; e = 21'h10; end
        default: begin a = 24'h050000; k = 2'h1; e = 21'h400; end
      endcase
      axw(OFS_CTRL, 32'h1, r);
      axw(OFS_CFG, 32'h0, r);
      hchk(a, k, 21'h0);
      axw(OFS_CFG, 32'h1 << i, r);
      hchk(a, k, e);
      axw(OFS_CTRL, 32'h0, r);
      axw(OFS_CFG, 32'h0, r);
      hchk(a, k, e);
    end
    axr(OFS_STAT, d, r);
    chk(d, 32'h80000000);
  endtask : t_gate
  task automatic t_map;
    for (int i = 0; i < 16; i++) hchk(24'(i) << 16, 2'h2, 21'h20 << i);
    hchk(24'h103FFE, 2'h2, 21'h2);
    hchk(24'h104000, 2'h2, 21'h4);
    hchk(24'h106000, 2'h2, 21'h8);
    hchk(24'h10FFFE, 2'h1, 21'h10);
    hchk(24'h117FFE, 2'h2, 21'h1);
    hchk(24'h118000, 2'h2, 21'h0);
  endtask : t_map
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_ids;
    t_gate;
    t_map;
    test_done;
  end
endmodule : testbench
